// [include/pts_cfg.svh]
`ifndef PTS_CFG_SVH
`define PTS_CFG_SVH
// header byte
`define PTS_HDR_RNW       7
`define PTS_HDR_BURST     6
`define PTS_TABLE_ADDR    6'h3E
`define PTS_STROBE_LO     6'h30
`define PTS_STROBE_HI     6'h3D
// status byte state codes
`define PTS_ST_IDLE       3'h0
`define PTS_ST_RSV_A      3'h1
`define PTS_ST_TX         3'h2
`define PTS_ST_RSV_B      3'h6
`define PTS_ST_UNDERFLOW  3'h7
`define PTS_FREE_SAT      7'h0F
// rate accumulator
`define PTS_RATE_BASE     16'h0001
`define PTS_RATE_CARRY    28
// link timing
`define PTS_PCLK_NS       10
`define PTS_SCLK_HALF_NS  100
`define PTS_SCLK_HALF     8'((`PTS_SCLK_HALF_NS + `PTS_PCLK_NS - 1) / `PTS_PCLK_NS)
// gdo1 functions
`define PTS_GDO1_TRI      2'h0
`define PTS_GDO1_UNDER    2'h1
`define PTS_GDO1_TX       2'h2
// host apb map
`define PTS_REG_CMD       8'h00
`define PTS_REG_TXLO      8'h04
`define PTS_REG_TXHI      8'h08
`define PTS_REG_RXLO      8'h0C
`define PTS_REG_RXHI      8'h10
`define PTS_REG_STAT      8'h14
`define PTS_CMD_GO        16
`define PTS_CMD_G0_DRV    17
`define PTS_CMD_G0_VAL    18
`define PTS_MAX_DATA      4'h8
`endif

// [include/pts_pkg.sv]
package pts_pkg;
  typedef enum logic {PTS_P_HDR, PTS_P_DATA} pts_phase_t;
  typedef enum logic [2:0] {PTS_H_IDLE, PTS_H_WAIT, PTS_H_LOW, PTS_H_HIGH, PTS_H_END,
                            PTS_H_GAP} pts_hstate_t;
  typedef logic [7:0] pts_byte_t;
endpackage

// [include/pts_if.sv]
`timescale 1ns/1ns
interface pts_if;
  logic cs_n;
  logic sclk;
  logic si;
  logic so_o;
  logic so_oe;
  logic so_line;
  logic g0_dev_o;
  logic g0_dev_oe;
  logic g0_host_o;
  logic g0_host_oe;
  logic g0_line;
  // shared lines: pulled high when undriven, general_output_0 low
  assign so_line = so_oe ? so_o : 1'b1;
  assign g0_line = g0_dev_oe ? g0_dev_o : (g0_host_oe ? g0_host_o : 1'b0);
  modport dev  (input cs_n, sclk, si, g0_line, output so_o, so_oe, g0_dev_o, g0_dev_oe);
  modport host (input so_line, output cs_n, sclk, si, g0_host_o, g0_host_oe);
endinterface

// [core/pts_dev.sv]
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ns
`include "pts_cfg.svh"
// Notes on behaviour
// [RQ1] header address 0x3E selects the table
// [RQ2] eight setting bytes, entry picked by index
// [RQ3] up to eight data bytes per table access
// [RQ4] index advances after every table byte
// [RQ5] chip select high returns index to 0
// [RQ6] burst index wraps from 7 to 0
// [RQ7] burst bit and read/write bit select access
// [RQ8] master raises select before reading back
// [RQ9] sleep clears all table entries
// [RQ10] status bit 7 high until clock stable
// [RQ11] status bits 6:4 report main state
// [RQ12] codes 001 and 110 never reported
// [RQ13] idle may stand for transitional states
// [RQ14] underflow code held until flush strobe
// [RQ15] bits 3:0 free count, saturating at 15
// [RQ16] shared pin three-state unless programmed
// [RQ17] select low makes shared pin serial out
// [RQ18] general_output_0 is serial tx input while sending
// [RQ19] rate from mantissa, exponent, crystal clock
// [RQ20] status byte shifts out during header
// [RQ21] header is rnw, burst, address; msb first
// [RQ22] underflow encoded as state code 111
// [RQ23] index advances once per eight clock edges
module pts_dev
  import pts_pkg::*;
(
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // link
  pts_if.dev              link,
  // core status
  input  wire logic       xtal_stable,
  input  wire logic [2:0] main_state,
  input  wire logic [6:0] tx_free_bytes,
  input  wire logic       underflow_evt,
  input  wire logic       flush_tx_strobe,
  input  wire logic       sleep_enter,
  // configuration
  input  wire logic [2:0] power_index_select,
  input  wire logic [1:0] gdo1_func,
  input  wire logic       serial_mode,
  input  wire logic [7:0] rate_mantissa,
  input  wire logic [3:0] rate_exponent,
  // results
  output logic [7:0]      pa_setting,
  output logic            tx_serial_bit,
  output logic            rate_tick,
  output logic            tx_underflow
);
  import pts_pkg::*;

  localparam int NIN = 4;
  logic [NIN-1:0] pin_in;
  logic [NIN-1:0] s1_r, s2_r, s3_r, lvl_r, lvl_q_r;
  assign pin_in = {link.g0_line, link.si, link.sclk, link.cs_n};

  // three-stage sync, level accepted when stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1_r[gi]    <= (gi == 0);
          s2_r[gi]    <= (gi == 0);
          s3_r[gi]    <= (gi == 0);
          lvl_r[gi]   <= (gi == 0);
          lvl_q_r[gi] <= (gi == 0);
        end else begin
          s1_r[gi] <= pin_in[gi];
          s2_r[gi] <= s1_r[gi];
          s3_r[gi] <= s2_r[gi];
          if (s2_r[gi] == s3_r[gi]) begin
            lvl_r[gi] <= s3_r[gi];
          end
          lvl_q_r[gi] <= lvl_r[gi];
        end
      end
    end
  endgenerate

  logic cs_n_l, cs_fall, sck_rise, sck_fall, si_l, g0_l;
  assign cs_n_l   = lvl_r[0];
  assign cs_fall  = lvl_q_r[0] & ~lvl_r[0];
  assign sck_rise = ~cs_n_l & lvl_r[1] & ~lvl_q_r[1];
  assign sck_fall = ~cs_n_l & ~lvl_r[1] & lvl_q_r[1];
  assign si_l     = lvl_r[2];
  assign g0_l     = lvl_r[3];

  // status byte
  logic       ready_n_r;
  logic       under_r;
  logic [2:0] state_code;
  logic [3:0] free_sat;
  pts_byte_t  status_byte;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_n_r <= 1'b1;
    end else begin
      ready_n_r <= ~xtal_stable; // RQ10
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      under_r <= 1'b0;
    end else if (underflow_evt) begin
      under_r <= 1'b1; // RQ14
    end else if (flush_tx_strobe) begin
      under_r <= 1'b0; // RQ14
    end
  end

  always_comb begin
    if (under_r) begin
      state_code = `PTS_ST_UNDERFLOW; // RQ22
    end else if (main_state == `PTS_ST_RSV_A || main_state == `PTS_ST_RSV_B) begin
      state_code = `PTS_ST_IDLE; // RQ12 RQ13
    end else begin
      state_code = main_state; // RQ11
    end
    if (tx_free_bytes >= `PTS_FREE_SAT) begin
      free_sat = 4'(`PTS_FREE_SAT); // RQ15
    end else begin
      free_sat = tx_free_bytes[3:0];
    end
  end
  assign status_byte = {ready_n_r, state_code, free_sat};

  // serial slave
  pts_byte_t  table_r [8];
  pts_byte_t  rx_sh_r, tx_sh_r, next_out_r;
  logic [2:0] bit_cnt_r, idx_r;
  pts_phase_t phase_r;
  logic       burst_r, rnw_r, hit_r;
  pts_byte_t  rx_nxt;
  logic       byte_done;
  assign rx_nxt    = {rx_sh_r[6:0], si_l}; // RQ21
  assign byte_done = sck_rise && bit_cnt_r == 3'h7; // RQ23

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_sh_r   <= 8'h00;
      bit_cnt_r <= 3'h0;
    end else if (cs_n_l) begin
      bit_cnt_r <= 3'h0;
    end else if (sck_rise) begin
      rx_sh_r   <= rx_nxt;
      bit_cnt_r <= bit_cnt_r + 3'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_r <= PTS_P_HDR;
      burst_r <= 1'b0;
      rnw_r   <= 1'b0;
      hit_r   <= 1'b0;
    end else if (cs_n_l) begin
      phase_r <= PTS_P_HDR;
    end else if (byte_done) begin
      case (phase_r)
        PTS_P_HDR: begin
          rnw_r   <= rx_nxt[`PTS_HDR_RNW]; // RQ7
          burst_r <= rx_nxt[`PTS_HDR_BURST]; // RQ7
          hit_r   <= rx_nxt[5:0] == `PTS_TABLE_ADDR; // RQ1
          if (!rx_nxt[`PTS_HDR_BURST] && rx_nxt[5:0] >= `PTS_STROBE_LO &&
              rx_nxt[5:0] <= `PTS_STROBE_HI) begin
            phase_r <= PTS_P_HDR;
          end else begin
            phase_r <= PTS_P_DATA;
          end
        end
        PTS_P_DATA: begin
          if (!burst_r) begin
            phase_r <= PTS_P_HDR; // RQ7
          end
        end
        default: phase_r <= PTS_P_HDR;
      endcase
    end
  end

  // table index and contents
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idx_r <= 3'h0;
    end else if (cs_n_l) begin
      idx_r <= 3'h0; // RQ5
    end else if (byte_done && phase_r == PTS_P_DATA && hit_r) begin
      idx_r <= idx_r + 3'h1; // RQ4 RQ6 RQ3
    end
  end

  generate
    for (gi = 0; gi < 8; gi++) begin : g_tbl
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          table_r[gi] <= 8'h00;
        end else if (sleep_enter) begin
          table_r[gi] <= 8'h00; // RQ9
        end else if (byte_done && phase_r == PTS_P_DATA && hit_r && !rnw_r &&
                     idx_r == 3'(gi)) begin
          table_r[gi] <= rx_nxt; // RQ2
        end
      end
    end
  endgenerate

  // shift-out path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      next_out_r <= 8'h00;
    end else if (byte_done) begin
      if (phase_r == PTS_P_HDR && rx_nxt[`PTS_HDR_RNW] &&
          rx_nxt[5:0] == `PTS_TABLE_ADDR) begin
        next_out_r <= table_r[idx_r];
      end else if (phase_r == PTS_P_DATA && hit_r && rnw_r && burst_r) begin
        next_out_r <= table_r[idx_r + 3'h1];
      end else begin
        next_out_r <= status_byte;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_sh_r <= 8'hFF;
    end else if (cs_fall) begin
      tx_sh_r <= status_byte; // RQ20
    end else if (sck_fall) begin
      if (bit_cnt_r == 3'h0) begin
        tx_sh_r <= next_out_r;
      end else begin
        tx_sh_r <= {tx_sh_r[6:0], 1'b0};
      end
    end
  end

  // shared status pin and general_output_0
  logic transmitting;
  assign transmitting = main_state == `PTS_ST_TX;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link.so_o      <= 1'b1;
      link.so_oe     <= 1'b0;
      link.g0_dev_o  <= 1'b0;
      link.g0_dev_oe <= 1'b0;
    end else begin
      if (!cs_n_l) begin
        link.so_o  <= tx_sh_r[7]; // RQ17
        link.so_oe <= 1'b1;
      end else begin
        link.so_o  <= (gdo1_func == `PTS_GDO1_UNDER) ? under_r :
                      (gdo1_func == `PTS_GDO1_TX) ? transmitting : ready_n_r;
        link.so_oe <= gdo1_func != `PTS_GDO1_TRI; // RQ16
      end
      link.g0_dev_o  <= under_r;
      link.g0_dev_oe <= !(serial_mode && transmitting); // RQ18
    end
  end

  // data rate accumulator, pclk stands for the crystal
  logic [23:0] rate_inc;
  logic [27:0] acc_r;
  logic [28:0] acc_sum;
  assign rate_inc = {`PTS_RATE_BASE, rate_mantissa} << rate_exponent; // RQ19
  assign acc_sum  = {1'b0, acc_r} + {5'h00, rate_inc};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_r         <= 28'h0000000;
      rate_tick     <= 1'b0;
      pa_setting    <= 8'h00;
      tx_serial_bit <= 1'b0;
      tx_underflow  <= 1'b0;
    end else begin
      acc_r        <= acc_sum[27:0];
      rate_tick    <= acc_sum[`PTS_RATE_CARRY]; // RQ19
      pa_setting   <= table_r[power_index_select]; // RQ2
      tx_underflow <= under_r;
      if (serial_mode && transmitting) begin
        tx_serial_bit <= g0_l; // RQ18
      end
    end
  end
endmodule

// [core/pts_host.sv]
`timescale 1ns/1ns
`include "pts_cfg.svh"
module pts_host
  import pts_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // link
  pts_if.host              link
);
  import pts_pkg::*;

  pts_hstate_t st_r;
  pts_byte_t   hdr_r, status_r, sh_r, rsh_r;
  logic [3:0]  cnt_r, byte_i_r;
  logic [2:0]  bit_r;
  logic [7:0]  tmr_r;
  logic [63:0] txbuf_r, rxbuf_r;
  logic        go_r, g0_drv_r, g0_val_r;
  logic        so1_r, so2_r, so3_r, so_l;
  logic        acc, wr_now;
  assign acc    = psel & penable;
  assign wr_now = acc & pready & pwrite;

  // apb: one wait state, data and error registered with pready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (acc && !pready) begin
      pready  <= 1'b1;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
      case (paddr)
        `PTS_REG_CMD:  prdata <= {13'h0000, g0_val_r, g0_drv_r, 1'b0, 4'h0, cnt_r, hdr_r};
        `PTS_REG_TXLO: prdata <= txbuf_r[31:0];
        `PTS_REG_TXHI: prdata <= txbuf_r[63:32];
        `PTS_REG_RXLO: prdata <= rxbuf_r[31:0];
        `PTS_REG_RXHI: prdata <= rxbuf_r[63:32];
        `PTS_REG_STAT: prdata <= {23'h000000, st_r != PTS_H_IDLE, status_r};
        default:       pslverr <= 1'b1;
      endcase
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hdr_r    <= 8'h00;
      cnt_r    <= 4'h0;
      txbuf_r  <= 64'h0000000000000000;
      go_r     <= 1'b0;
      g0_drv_r <= 1'b0;
      g0_val_r <= 1'b0;
    end else begin
      go_r <= 1'b0;
      if (wr_now && paddr == `PTS_REG_CMD) begin
        hdr_r    <= pwdata[7:0];
        cnt_r    <= (pwdata[11:8] > `PTS_MAX_DATA) ? `PTS_MAX_DATA : pwdata[11:8];
        go_r     <= pwdata[`PTS_CMD_GO];
        g0_drv_r <= pwdata[`PTS_CMD_G0_DRV];
        g0_val_r <= pwdata[`PTS_CMD_G0_VAL];
      end
      if (wr_now && paddr == `PTS_REG_TXLO) begin
        txbuf_r[31:0] <= pwdata;
      end
      if (wr_now && paddr == `PTS_REG_TXHI) begin
        txbuf_r[63:32] <= pwdata;
      end
    end
  end

  // serial output sync
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      so1_r <= 1'b1;
      so2_r <= 1'b1;
      so3_r <= 1'b1;
      so_l  <= 1'b1;
    end else begin
      so1_r <= link.so_line;
      so2_r <= so1_r;
      so3_r <= so2_r;
      if (so2_r == so3_r) begin
        so_l <= so3_r;
      end
    end
  end

  // transfer engine, sclk made by divider, mode 0
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r            <= PTS_H_IDLE;
      link.cs_n       <= 1'b1;
      link.sclk       <= 1'b0;
      link.si         <= 1'b0;
      link.g0_host_o  <= 1'b0;
      link.g0_host_oe <= 1'b0;
      sh_r            <= 8'h00;
      rsh_r           <= 8'h00;
      status_r        <= 8'h00;
      rxbuf_r         <= 64'h0000000000000000;
      byte_i_r        <= 4'h0;
      bit_r           <= 3'h0;
      tmr_r           <= 8'h00;
    end else begin
      link.g0_host_o  <= g0_val_r;
      link.g0_host_oe <= g0_drv_r;
      tmr_r           <= tmr_r + 8'h01;
      case (st_r)
        PTS_H_IDLE: begin
          if (go_r) begin
            link.cs_n <= 1'b0;
            st_r      <= PTS_H_WAIT;
          end
        end
        PTS_H_WAIT: begin
          if (!so_l) begin
            sh_r     <= {hdr_r[6:0], 1'b0};
            link.si  <= hdr_r[7];
            byte_i_r <= 4'h0;
            bit_r    <= 3'h0;
            tmr_r    <= 8'h00;
            st_r     <= PTS_H_LOW;
          end
        end
        PTS_H_LOW: begin
          if (tmr_r == `PTS_SCLK_HALF - 8'h01) begin
            link.sclk <= 1'b1;
            tmr_r     <= 8'h00;
            st_r      <= PTS_H_HIGH;
          end
        end
        PTS_H_HIGH: begin
          if (tmr_r == `PTS_SCLK_HALF - 8'h01) begin
            link.sclk <= 1'b0;
            tmr_r     <= 8'h00;
            bit_r     <= bit_r + 3'h1;
            rsh_r     <= {rsh_r[6:0], so_l};
            st_r      <= PTS_H_LOW;
            if (bit_r == 3'h7) begin
              if (byte_i_r == 4'h0) begin
                status_r <= {rsh_r[6:0], so_l};
              end else begin
                rxbuf_r[6'({byte_i_r[2:0] - 3'h1, 3'h0}) +: 8] <= {rsh_r[6:0], so_l};
              end
              if (byte_i_r == cnt_r) begin
                st_r <= PTS_H_END;
              end else begin
                sh_r     <= {txbuf_r[6'({byte_i_r[2:0], 3'h0}) +: 7], 1'b0};
                link.si  <= txbuf_r[6'({byte_i_r[2:0], 3'h7})];
                byte_i_r <= byte_i_r + 4'h1;
              end
            end else begin
              link.si <= sh_r[7];
              sh_r    <= {sh_r[6:0], 1'b0};
            end
          end
        end
        PTS_H_END: begin
          if (tmr_r == `PTS_SCLK_HALF - 8'h01) begin
            link.cs_n <= 1'b1;
            tmr_r     <= 8'h00;
            st_r      <= PTS_H_GAP;
          end
        end
        PTS_H_GAP: begin
          if (tmr_r == `PTS_SCLK_HALF - 8'h01) begin
            st_r <= PTS_H_IDLE;
          end
        end
        default: st_r <= PTS_H_IDLE;
      endcase
    end
  end
endmodule

// [test/pts_sva.sv]
`timescale 1ns/1ns
module pts_sva (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // link
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic si,
  input wire logic so_oe,
  input wire logic g0_dev_oe,
  input wire logic g0_host_oe
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // one serial clock half is ten core cycles
  sequence s_high;
    sclk [*8] ##1 sclk ##1 sclk ##1 !sclk;
  endsequence
  sequence s_low;
    !sclk [*8] ##1 !sclk;
  endsequence

  property p_clk_in_frame;
    sclk |-> !cs_n;
  endproperty
  property p_high_half;
    $rose(sclk) |-> s_high;
  endproperty
  property p_low_half;
    $fell(sclk) |-> s_low ##[1:2] (sclk || cs_n);
  endproperty
  property p_si_stable;
    $rose(sclk) |-> $stable(si) [*8];
  endproperty
  property p_so_drive;
    !cs_n [*8] |-> so_oe;
  endproperty
  property p_so_release;
    $fell(so_oe) |-> cs_n && $past(cs_n, 2);
  endproperty
  property p_gap;
    $rose(cs_n) |-> cs_n [*8];
  endproperty
  property p_g0_single;
    !(g0_dev_oe && g0_host_oe);
  endproperty

  a_clk_in_frame: assert property (p_clk_in_frame) else $error("sclk outside frame");
  a_high_half:    assert property (p_high_half) else $error("sclk high half length");
  a_low_half:     assert property (p_low_half) else $error("sclk low half length");
  a_si_stable:    assert property (p_si_stable) else $error("si moved while sclk high");
  a_so_drive:     assert property (p_so_drive) else $error("so not driven in frame");
  a_so_release:   assert property (p_so_release) else $error("so released in frame");
  a_gap:          assert property (p_gap) else $error("select gap too short");
  a_g0_single:    assert property (p_g0_single) else $error("general_output_0 driven twice");
endmodule

// [test/pts_bench.sv]
`timescale 1ns/1ns
`include "pts_cfg.svh"
module pa_table_and_status_port_bench;
  import pts_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        xtal_stable = 1'b1;
  logic [2:0]  main_state = 3'h0;
  logic [6:0]  tx_free_bytes = 7'h00;
  logic        underflow_evt = 1'b0;
  logic        flush_tx_strobe = 1'b0;
  logic        sleep_enter = 1'b0;
  logic [2:0]  power_index_select = 3'h0;
  logic [1:0]  gdo1_func = 2'h0;
  logic        serial_mode = 1'b0;
  logic [7:0]  rate_mantissa = 8'h00;
  logic [3:0]  rate_exponent = 4'h0;
  logic [7:0]  pa_setting;
  logic        tx_serial_bit;
  logic        rate_tick;
  logic        tx_underflow;
  int          miscompares = 0;
  int          checked = 0;
  logic [31:0] rd;
  logic        perr;
  logic [7:0]  st;
  logic [63:0] rx;
  logic        sclk_q = 1'b0;
  logic        cs_q = 1'b1;
  logic [7:0]  nbits = 8'h00;
  logic [7:0]  mon_hdr = 8'h00;

  pts_if link ();
  pts_dev pts_dev_inst (.pclk(pclk), .presetn(presetn), .link(link.dev),
    .xtal_stable(xtal_stable), .main_state(main_state), .tx_free_bytes(tx_free_bytes),
    .underflow_evt(underflow_evt), .flush_tx_strobe(flush_tx_strobe),
    .sleep_enter(sleep_enter), .power_index_select(power_index_select),
    .gdo1_func(gdo1_func), .serial_mode(serial_mode), .rate_mantissa(rate_mantissa),
    .rate_exponent(rate_exponent), .pa_setting(pa_setting), .tx_serial_bit(tx_serial_bit),
    .rate_tick(rate_tick), .tx_underflow(tx_underflow));
  pts_host pts_host_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(link.host));
  pts_sva pts_sva_inst (.pclk(pclk), .presetn(presetn), .cs_n(link.cs_n),
    .sclk(link.sclk), .si(link.si), .so_oe(link.so_oe), .g0_dev_oe(link.g0_dev_oe),
    .g0_host_oe(link.g0_host_oe));

  always #5 pclk = ~pclk;

  // wire monitor: header bits and bit count of each frame
  always @(posedge pclk) begin
    sclk_q <= link.sclk;
    cs_q <= link.cs_n;
    if (cs_q && !link.cs_n) nbits <= 8'h00;
    else if (link.sclk && !sclk_q) begin
      nbits <= nbits + 8'h01;
      if (nbits < 8'h08) mon_hdr <= {mon_hdr[6:0], link.si};
    end
  end

  task chk(input logic ok, input string m);
    checked++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask

  task end_of_test;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 20 && pready !== 1'b1; k++) @(posedge pclk);
    if (k == 20) begin
      chk(1'b0, "bus wait ran out");
      end_of_test;
    end
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task xfer(input logic [7:0] h, input logic [3:0] n, input logic [63:0] tx);
    int k;
    apb(1'b1, `PTS_REG_TXLO, tx[31:0]);
    apb(1'b1, `PTS_REG_TXHI, tx[63:32]);
    apb(1'b1, `PTS_REG_CMD, {15'h0000, 1'b1, 4'h0, n, h});
    rd = 32'h0000_0100;
    for (k = 0; k < 400 && rd[8] !== 1'b0; k++) apb(1'b0, `PTS_REG_STAT, 32'h0);
    if (k == 400) begin
      chk(1'b0, "frame never ended");
      end_of_test;
    end
    st = rd[7:0];
    apb(1'b0, `PTS_REG_RXLO, 32'h0);
    rx[31:0] = rd;
    apb(1'b0, `PTS_REG_RXHI, 32'h0);
    rx[63:32] = rd;
    chk(mon_hdr === h, "header bits on wire");
    chk(nbits === 8'({n, 3'b000} + 8), "bits in frame");
  endtask

  task t_pins;
    logic v;
    gdo1_func <= 2'h0;
    repeat (6) @(posedge pclk);
    chk(link.so_oe === 1'b0, "shared pin driven");
    gdo1_func <= 2'h1;
    repeat (6) @(posedge pclk);
    chk(link.so_oe === 1'b1, "shared pin not driven");
    chk(link.so_line === 1'b0, "underflow flag on shared pin");
    gdo1_func <= 2'h3;
    xtal_stable <= 1'b0;
    repeat (6) @(posedge pclk);
    chk(link.so_line === 1'b1, "ready flag low before clock stable");
    xtal_stable <= 1'b1;
    repeat (6) @(posedge pclk);
    chk(link.so_line === 1'b0, "ready flag stuck high");
    gdo1_func <= 2'h2;
    serial_mode <= 1'b1;
    main_state <= `PTS_ST_TX;
    for (int i = 0; i < 2; i++) begin
      v = i[0];
      repeat (6) @(posedge pclk);
      apb(1'b1, `PTS_REG_CMD, {13'h0000, v, 1'b1, 17'h00000});
      repeat (8) @(posedge pclk);
      chk(tx_serial_bit === v, "serial tx bit");
    end
    chk(link.so_line === 1'b1, "transmitting flag on shared pin");
    gdo1_func <= 2'h0;
    apb(1'b1, `PTS_REG_CMD, 32'h0);
    repeat (2) @(posedge pclk);
    serial_mode <= 1'b0;
    main_state <= `PTS_ST_IDLE;
    apb(1'b0, 8'h40, 32'h0);
    chk(perr === 1'b1 && rd === 32'h0, "unmapped address");
    $display("done: pins");
  endtask

  task t_table;
    xfer(8'h7E, 4'h8, 64'h8877_6655_4433_2211);
    for (int i = 0; i < 8; i++) begin
      power_index_select <= i[2:0];
      repeat (3) @(posedge pclk);
      chk(pa_setting === 8'(8'h11 * (i + 1)), "table entry");
    end
    xfer(8'hFE, 4'h8, 64'h0);
    chk(rx === 64'h8877_6655_4433_2211, "burst read");
    xfer(8'h3E, 4'h7, 64'h00C4_3EC3_3EC2_3EC1);
    xfer(8'hBE, 4'h7, {8'h00, 8'h00, 8'hBE, 8'h00, 8'hBE, 8'h00, 8'hBE, 8'h00});
    chk({rx[55:48], rx[39:32], rx[23:16], rx[7:0]} === 32'hC4C3_C2C1, "single");
    power_index_select <= 3'h0;
    xfer(8'h05, 4'h1, 64'h5A);
    chk(pa_setting === 8'hC1, "table hit by other address");
    $display("done: table");
  endtask

  task t_sleep;
    sleep_enter <= 1'b1;
    @(posedge pclk);
    sleep_enter <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(pa_setting === 8'h00, "table kept over sleep");
    $display("done: sleep");
  endtask

  task t_status;
    logic [2:0] e;
    for (int i = 0; i < 8; i++) begin
      main_state <= i[2:0];
      tx_free_bytes <= 7'(i + 12);
      e = (i == 1 || i == 6) ? 3'h0 : i[2:0];
      xfer(8'h80, 4'h0, 64'h0);
      chk(st === {1'b0, e, (i < 4 ? 4'(i + 12) : 4'hF)}, "status byte");
    end
    main_state <= `PTS_ST_IDLE;
    underflow_evt <= 1'b1;
    @(posedge pclk);
    underflow_evt <= 1'b0;
    xfer(8'h80, 4'h0, 64'h0);
    chk(st[6:4] === `PTS_ST_UNDERFLOW && tx_underflow === 1'b1, "underflow");
    flush_tx_strobe <= 1'b1;
    @(posedge pclk);
    flush_tx_strobe <= 1'b0;
    xfer(8'h80, 4'h0, 64'h0);
    chk(st[6:4] === `PTS_ST_IDLE && tx_underflow === 1'b0, "underflow kept");
    $display("done: status");
  endtask

  task t_rate;
    int cnt;
    for (int i = 0; i < 2; i++) begin
      rate_mantissa <= i == 0 ? 8'h00 : 8'h80;
      rate_exponent <= i == 0 ? 4'hF : 4'hE;
      repeat (4) @(posedge pclk);
      cnt = 0;
      repeat (640) begin
        @(posedge pclk);
        if (rate_tick === 1'b1) cnt++;
      end
      chk(cnt >= 19 - 5 * i && cnt <= 21 - 5 * i, "rate ticks");
    end
    $display("done: rate");
  endtask

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_pins();
    t_table();
    t_sleep();
    t_status();
    t_rate();
    end_of_test();
  end
endmodule
